// file: design/vmat_pkg.sv
package vmat_pkg;

    // Register offsets of the controller's own APB map
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_PARAM = 8'h04;
    localparam logic [7:0] OFF_BSIZE = 8'h08;
    localparam logic [7:0] OFF_STATUS = 8'h0C;
    localparam logic [7:0] OFF_PTR = 8'h10;
    localparam logic [7:0] OFF_DATA = 8'h14;

    // Control register fields
    localparam int CTRL_START_BIT = 0;
    localparam int CTRL_OP_LSB = 1;
    localparam int CTRL_FAM_LSB = 3;
    localparam int CTRL_OPT_BIT = 5;
    localparam int CTRL_PEXT_BIT = 6;

    // Parameter register fields
    localparam int PARAM_ADDR_LSB = 0;
    localparam int PARAM_LEN_LSB = 16;
    localparam int PARAM_CMD_LSB = 24;

    // Status register fields
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_DONE_BIT = 1;
    localparam int STAT_ERR_BIT = 2;
    localparam int STAT_SW2_LSB = 8;
    localparam int STAT_SW1_LSB = 16;
    localparam int STAT_RXCNT_LSB = 24;

    // Reset values
    localparam logic [31:0] PARAM_RST = 32'h0000_0000;
    localparam logic [3:0] BSIZE_RST = 4'h4;
    localparam logic [7:0] PTR_RST = 8'h00;

    // Command APDU bytes
    localparam logic [7:0] APDU_CLA = 8'hFF;
    localparam logic [7:0] INS_READ = 8'hB0;
    localparam logic [7:0] INS_UPDATE = 8'hD6;
    localparam logic [7:0] INS_RAW = 8'hFE;
    localparam logic [7:0] RAW_P1_UID = 8'h05;
    localparam logic [7:0] RAW_P2 = 8'h00;
    localparam logic [7:0] ZERO_BYTE = 8'h00;

    // Command flags byte of the raw pass-through frame
    localparam logic [7:0] FLAGS_BASE = 8'h22;
    localparam logic [7:0] FLAG_OPT_MASK = 8'h40;
    localparam logic [7:0] FLAG_PEXT_MASK = 8'h08;

    // Basic tag command codes
    localparam logic [7:0] CMD_RD_BLOCK = 8'h20;
    localparam logic [7:0] CMD_WR_BLOCK = 8'h21;
    localparam logic [7:0] CMD_LOCK_BLOCK = 8'h22;
    localparam logic [7:0] CMD_WR_AFI = 8'h27;
    localparam logic [7:0] CMD_LOCK_AFI = 8'h28;
    localparam logic [7:0] CMD_WR_DSFID = 8'h29;
    localparam logic [7:0] CMD_LOCK_DSFID = 8'h2A;
    localparam logic [7:0] CMD_SYS_INFO = 8'h2B;

    // Frame lengths
    localparam logic [7:0] STD_HDR_LEN = 8'h05;
    localparam logic [7:0] RAW_HDR_LEN = 8'h07;
    localparam logic [7:0] RAW_LC_BASE = 8'h02;

    // Tag family geometry
    localparam logic [7:0] T3_BLOCK_BYTES = 8'h10;
    localparam logic [7:0] T3_MAX_LE = 8'h80;
    localparam logic [7:0] WORD_BYTES = 8'h04;
    localparam logic [7:0] WORD_LAST = 8'h0F;
    localparam logic [7:0] WORD_MAX_LE = 8'h40;

    // Response buffer depth
    localparam int BUF_DEPTH = 256;

    typedef enum logic [1:0] {
        OP_READ,
        OP_UPDATE,
        OP_RAW,
        OP_NONE
    } vmat_op_type;

    typedef enum logic [1:0] {
        FAM_VICINITY_TAG,
        FAM_VICINITY_TAG_EXT,
        FAM_T3,
        FAM_WORD
    } vmat_fam_type;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_HDR,
        ST_FETCH,
        ST_LOAD,
        ST_SEND_HI,
        ST_SEND_LO,
        ST_RX_WAIT,
        ST_RX_LO
    } vmat_state_type;

endpackage : vmat_pkg

// file: design/vmat_buf_if.sv
`timescale 1ns/1ps
`default_nettype none
interface vmat_buf_if;
    logic we;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;

    modport user (output we, output addr, output wdata, input rdata);
    modport mem (input we, input addr, input wdata, output rdata);
endinterface : vmat_buf_if
`default_nettype wire

// file: design/vmat_buf.sv
`timescale 1ns/1ps
`default_nettype none
module vmat_buf
    import vmat_pkg::*;
(
    input wire logic clk_in,
    vmat_buf_if.mem bus
);
    logic [7:0] mem_q [0:BUF_DEPTH-1];
    logic [7:0] rdata_q;

    // Single port, read data registered one cycle after the address
    always_ff @(posedge clk_in) begin
        if (bus.we) begin
            mem_q[bus.addr] <= bus.wdata;
        end
        rdata_q <= mem_q[bus.addr];
    end

    assign bus.rdata = rdata_q;
endmodule : vmat_buf
`default_nettype wire

// file: design/vmat_host.sv
// Added by the designer: the APB register port and the address map.
`timescale 1ns/1ps
`default_nettype none
module vmat_host (
    input wire logic core_clk_in,
    input wire logic rst_b_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [7:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    output logic [7:0] cmd_byte_out,
    output logic cmd_req_out,
    input wire logic cmd_ack_in,
    input wire logic [7:0] rsp_byte_in,
    input wire logic rsp_last_in,
    input wire logic rsp_req_in,
    output logic rsp_ack_out,
    output logic busy_out
);
    import vmat_pkg::*;

    vmat_buf_if buf_bus ();

    // Configuration held while a request runs
    vmat_op_type op_q;
    vmat_fam_type fam_q;
    logic opt_q;
    logic pext_q;
    logic [31:0] param_q;
    logic [3:0] bsize_q;
    logic [7:0] ptr_q;

    // Sequencer state
    vmat_state_type state_q;
    logic [7:0] cnt_q;
    logic [7:0] rx_cnt_q;
    logic [7:0] tx_byte_q;
    logic cmd_req_q;
    logic rsp_ack_q;
    logic last_q;
    logic [7:0] sw1_q;
    logic [7:0] sw2_q;
    logic done_q;
    logic err_q;

    // Two-flop synchronisers for everything the device drives
    logic [10:0] link_meta_q;
    logic [10:0] link_sync_q;
    logic ack_s;
    logic rsp_req_s;
    logic rsp_last_s;
    logic [7:0] rsp_byte_s;

    // Size of one block for the present family
    function automatic logic [7:0] blk_size(input vmat_fam_type fam, input logic [3:0] bs);
        if (fam == FAM_T3) begin
            return T3_BLOCK_BYTES;
        end else if (fam == FAM_WORD) begin
            return WORD_BYTES;
        end else begin
            return {4'h0, bs};
        end
    endfunction : blk_size

    // Commands that carry one parameter byte after the code
    function automatic logic has_param(input logic [7:0] cmd);
        return (cmd == CMD_RD_BLOCK) || (cmd == CMD_WR_BLOCK) || (cmd == CMD_LOCK_BLOCK)
            || (cmd == CMD_WR_AFI) || (cmd == CMD_WR_DSFID);
    endfunction : has_param

    // Recognised basic command codes
    function automatic logic cmd_known(input logic [7:0] cmd);
        return has_param(cmd) || (cmd == CMD_LOCK_AFI) || (cmd == CMD_LOCK_DSFID)
            || (cmd == CMD_SYS_INFO);
    endfunction : cmd_known

    // APB decode
    logic setup_w;
    logic access_w;
    logic hit_ctrl_w;
    logic hit_param_w;
    logic hit_bsize_w;
    logic hit_status_w;
    logic hit_ptr_w;
    logic hit_data_w;
    logic mapped_w;
    logic wr_w;
    logic rd_w;
    logic busy_w;

    assign setup_w = psel_in && !penable_in;
    assign access_w = psel_in && penable_in;
    assign hit_ctrl_w = (paddr_in == OFF_CTRL);
    assign hit_param_w = (paddr_in == OFF_PARAM);
    assign hit_bsize_w = (paddr_in == OFF_BSIZE);
    assign hit_status_w = (paddr_in == OFF_STATUS);
    assign hit_ptr_w = (paddr_in == OFF_PTR);
    assign hit_data_w = (paddr_in == OFF_DATA);
    assign mapped_w = hit_ctrl_w || hit_param_w || hit_bsize_w || hit_status_w
        || hit_ptr_w || hit_data_w;
    assign wr_w = access_w && pwrite_in;
    assign rd_w = access_w && !pwrite_in;
    assign busy_w = (state_q != ST_IDLE);

    // Fields of the pending request
    logic [15:0] addr_w;
    logic [7:0] len_w;
    logic [7:0] cmd_w;
    logic [7:0] bs_w;

    assign addr_w = param_q[PARAM_ADDR_LSB +: 16];
    assign len_w = param_q[PARAM_LEN_LSB +: 8];
    assign cmd_w = param_q[PARAM_CMD_LSB +: 8];
    assign bs_w = blk_size(fam_q, bsize_q);

    // Checks made before any byte goes to the device
    logic vicinity_tag_w;
    logic bs_ok_w;
    logic p1_ok_w;
    logic mult_ok_w;
    logic word_ok_w;
    logic max_ok_w;
    logic rd_ok_w;
    logic upd_ok_w;
    logic raw_ok_w;
    logic req_ok_w;

    assign vicinity_tag_w = (fam_q == FAM_VICINITY_TAG) || (fam_q == FAM_VICINITY_TAG_EXT);
    assign bs_ok_w = !vicinity_tag_w || (bsize_q == 4'h1) || (bsize_q == 4'h4) || (bsize_q == 4'h8);
    assign p1_ok_w = (fam_q == FAM_VICINITY_TAG_EXT) || (addr_w[15:8] == ZERO_BYTE);
    assign mult_ok_w = ((len_w & (bs_w - 8'h01)) == ZERO_BYTE);
    assign word_ok_w = (fam_q != FAM_WORD) || (addr_w[7:0] <= WORD_LAST);
    assign max_ok_w = (fam_q == FAM_T3) ? (len_w <= T3_MAX_LE)
        : (fam_q == FAM_WORD) ? (len_w <= WORD_MAX_LE) : 1'b1;
    assign rd_ok_w = p1_ok_w && mult_ok_w && word_ok_w && max_ok_w;
    assign upd_ok_w = p1_ok_w && word_ok_w && (len_w == bs_w);
    assign raw_ok_w = vicinity_tag_w && cmd_known(cmd_w);
    assign req_ok_w = bs_ok_w && ((op_q == OP_READ) ? rd_ok_w
        : (op_q == OP_UPDATE) ? upd_ok_w
        : (op_q == OP_RAW) ? raw_ok_w : 1'b0);

    // Frame geometry
    logic [7:0] raw_lc_w;
    logic [7:0] hdr_len_w;
    logic [7:0] data_len_w;
    logic [7:0] total_w;
    logic [7:0] flags_w;
    logic [7:0] hdr_byte_w;

    assign raw_lc_w = RAW_LC_BASE + {7'h00, has_param(cmd_w)}
        + ((cmd_w == CMD_WR_BLOCK) ? bs_w : ZERO_BYTE);
    assign hdr_len_w = (op_q == OP_RAW) ? (RAW_HDR_LEN + {7'h00, has_param(cmd_w)})
        : STD_HDR_LEN;
    assign data_len_w = (op_q == OP_UPDATE) ? len_w
        : ((op_q == OP_RAW) && (cmd_w == CMD_WR_BLOCK)) ? bs_w : ZERO_BYTE;
    assign total_w = hdr_len_w + data_len_w;
    assign flags_w = FLAGS_BASE | (opt_q ? FLAG_OPT_MASK : ZERO_BYTE)
        | (pext_q ? FLAG_PEXT_MASK : ZERO_BYTE);

    // Header byte for the current index; Le is dropped from raw frames
    function automatic logic [7:0] hdr_byte(input logic [7:0] idx);
        case (idx)
            8'h00: return APDU_CLA;
            8'h01: return (op_q == OP_RAW) ? INS_RAW
                : (op_q == OP_UPDATE) ? INS_UPDATE : INS_READ;
            8'h02: return (op_q == OP_RAW) ? RAW_P1_UID : addr_w[15:8];
            8'h03: return (op_q == OP_RAW) ? RAW_P2 : addr_w[7:0];
            8'h04: return (op_q == OP_RAW) ? raw_lc_w : len_w;
            8'h05: return flags_w;
            8'h06: return cmd_w;
            default: return addr_w[7:0];
        endcase
    endfunction : hdr_byte

    assign hdr_byte_w = hdr_byte(cnt_q);

    // Buffer port: software owns it while idle, the sequencer while busy
    logic sw_we_w;
    logic rx_we_w;

    assign sw_we_w = wr_w && hit_data_w && !busy_w;
    assign rx_we_w = (state_q == ST_RX_WAIT) && rsp_req_s;
    assign buf_bus.we = sw_we_w || rx_we_w;
    assign buf_bus.wdata = rx_we_w ? rsp_byte_s : pwdata_in[7:0];
    assign buf_bus.addr = (state_q == ST_FETCH) ? (cnt_q - hdr_len_w)
        : busy_w ? rx_cnt_q : ptr_q;

    vmat_buf u_buf (
        .clk_in(core_clk_in),
        .bus(buf_bus)
    );

    // Register read mux; zero-wait slave, error on unmapped offsets
    logic [31:0] status_w;

    assign status_w = {rx_cnt_q, sw1_q, sw2_q, 5'h00, err_q, done_q, busy_w};
    assign prdata_out = hit_ctrl_w ? {25'h0, pext_q, opt_q, fam_q, op_q, busy_w}
        : hit_param_w ? param_q
        : hit_bsize_w ? {28'h0, bsize_q}
        : hit_status_w ? status_w
        : hit_ptr_w ? {24'h0, ptr_q}
        : hit_data_w ? {24'h0, buf_bus.rdata} : 32'h0000_0000;
    assign pready_out = 1'b1;
    assign pslverr_out = access_w && !mapped_w;

    // Device lines as seen after the second stage
    assign ack_s = link_sync_q[0];
    assign rsp_req_s = link_sync_q[1];
    assign rsp_last_s = link_sync_q[2];
    assign rsp_byte_s = link_sync_q[10:3];

    // Synchroniser stage one feeds only stage two; byte and marker settle
    // before the request moves, so they may ride beside it
    always_ff @(posedge core_clk_in) begin
        link_meta_q <= {rsp_byte_in, rsp_last_in, rsp_req_in, cmd_ack_in};
        link_sync_q <= link_meta_q;
    end

    // Configuration writes are ignored while a request runs
    always_ff @(posedge core_clk_in) begin
        if (!rst_b_in) begin
            op_q <= OP_READ;
            fam_q <= FAM_VICINITY_TAG;
            opt_q <= 1'b0;
            pext_q <= 1'b0;
            param_q <= PARAM_RST;
            bsize_q <= BSIZE_RST;
        end else if (wr_w && !busy_w) begin
            if (hit_ctrl_w) begin
                op_q <= vmat_op_type'(pwdata_in[CTRL_OP_LSB +: 2]);
                fam_q <= vmat_fam_type'(pwdata_in[CTRL_FAM_LSB +: 2]);
                opt_q <= pwdata_in[CTRL_OPT_BIT];
                pext_q <= pwdata_in[CTRL_PEXT_BIT];
            end else if (hit_param_w) begin
                param_q <= pwdata_in;
            end else if (hit_bsize_w) begin
                bsize_q <= pwdata_in[3:0];
            end
        end
    end

    // Buffer pointer for software access, held rewound while a request runs
    always_ff @(posedge core_clk_in) begin
        if (!rst_b_in) begin
            ptr_q <= PTR_RST;
        end else if (busy_w) begin
            ptr_q <= PTR_RST;
        end else if (access_w && hit_ptr_w && pwrite_in) begin
            ptr_q <= pwdata_in[7:0];
        end else if (access_w && hit_data_w) begin
            ptr_q <= ptr_q + 8'h01;
        end
    end

    // Start strobe decoded from the control write
    logic start_w;
    logic rx_end_w;
    logic clr_w;
    logic start_q;

    assign start_w = wr_w && hit_ctrl_w && !busy_w && pwdata_in[CTRL_START_BIT];
    assign rx_end_w = (state_q == ST_RX_LO) && !rsp_req_s && last_q;
    assign clr_w = wr_w && hit_status_w && pwdata_in[STAT_DONE_BIT];

    // Start acts one edge late, so the checks see the fields of the same write
    always_ff @(posedge core_clk_in) begin
        if (!rst_b_in) begin
            start_q <= 1'b0;
        end else begin
            start_q <= start_w;
        end
    end

    // Sticky completion flags; a setting event beats a software clear
    always_ff @(posedge core_clk_in) begin
        if (!rst_b_in) begin
            done_q <= 1'b0;
            err_q <= 1'b0;
        end else begin
            done_q <= rx_end_w || (start_q && !req_ok_w) || (done_q && !clr_w);
            err_q <= (start_q && !req_ok_w) || (err_q && !clr_w && !start_q);
        end
    end

    // Request sequencer: four-phase byte handshakes out, then in
    always_ff @(posedge core_clk_in) begin
        if (!rst_b_in) begin
            state_q <= ST_IDLE;
            cnt_q <= 8'h00;
            rx_cnt_q <= 8'h00;
            tx_byte_q <= 8'h00;
            cmd_req_q <= 1'b0;
            rsp_ack_q <= 1'b0;
            last_q <= 1'b0;
            sw1_q <= 8'h00;
            sw2_q <= 8'h00;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (start_q && req_ok_w) begin
                        cnt_q <= 8'h00;
                        rx_cnt_q <= 8'h00;
                        state_q <= ST_HDR;
                    end
                end
                ST_HDR: begin
                    tx_byte_q <= hdr_byte_w;
                    cmd_req_q <= 1'b1;
                    state_q <= ST_SEND_HI;
                end
                ST_FETCH: begin
                    state_q <= ST_LOAD;
                end
                ST_LOAD: begin
                    tx_byte_q <= buf_bus.rdata;
                    cmd_req_q <= 1'b1;
                    state_q <= ST_SEND_HI;
                end
                ST_SEND_HI: begin
                    if (ack_s) begin
                        cmd_req_q <= 1'b0;
                        state_q <= ST_SEND_LO;
                    end
                end
                ST_SEND_LO: begin
                    if (!ack_s) begin
                        cnt_q <= cnt_q + 8'h01;
                        if (cnt_q + 8'h01 == total_w) begin
                            state_q <= ST_RX_WAIT;
                        end else if (cnt_q + 8'h01 < hdr_len_w) begin
                            state_q <= ST_HDR;
                        end else begin
                            state_q <= ST_FETCH;
                        end
                    end
                end
                ST_RX_WAIT: begin
                    // Last two bytes seen are the status word
                    if (rsp_req_s) begin
                        sw1_q <= sw2_q;
                        sw2_q <= rsp_byte_s;
                        last_q <= rsp_last_s;
                        rsp_ack_q <= 1'b1;
                        state_q <= ST_RX_LO;
                    end
                end
                default: begin
                    if (!rsp_req_s) begin
                        rsp_ack_q <= 1'b0;
                        rx_cnt_q <= rx_cnt_q + 8'h01;
                        state_q <= last_q ? ST_IDLE : ST_RX_WAIT;
                    end
                end
            endcase
        end
    end

    assign cmd_byte_out = tx_byte_q;
    assign cmd_req_out = cmd_req_q;
    assign rsp_ack_out = rsp_ack_q;
    assign busy_out = busy_w;
endmodule : vmat_host
`default_nettype wire

// file: bench/vmat_host_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module vmat_host_asserts (
    input wire logic core_clk_in,
    input wire logic rst_b_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pslverr_out,
    input wire logic [7:0] cmd_byte_out,
    input wire logic cmd_req_out,
    input wire logic cmd_ack_in,
    input wire logic rsp_req_in,
    input wire logic rsp_ack_out,
    input wire logic busy_out
);
    logic [7:0] idx_q;
    logic [7:0] idx_d;
    logic [7:0] ins_q;
    logic req_q;
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (!rst_b_in);
    // Frame byte position, bumped when the request falls
    assign idx_d = !busy_out ? 8'h0 : (req_q && !cmd_req_out) ? idx_q + 8'h1 : idx_q;
    // Instruction byte kept so later positions can be judged
    always_ff @(posedge core_clk_in) begin
        req_q <= cmd_req_out;
        idx_q <= idx_d;
        if (cmd_req_out && idx_q == 8'h1) ins_q <= cmd_byte_out;
    end
    sequence launch_s;
        $rose(busy_out) ##[1:4] $rose(cmd_req_out);
    endsequence
    sequence acked_s;
        cmd_req_out && $rose(cmd_ack_in);
    endsequence
    head_byte_a: assert property (launch_s |-> cmd_byte_out == 8'hFF)
        else $error("frame opens with wrong byte");
    byte_hold_a: assert property (cmd_req_out && req_q |-> $stable(cmd_byte_out))
        else $error("byte moved while offered");
    req_drop_a: assert property (acked_s |-> ##[1:6] !cmd_req_out)
        else $error("request not withdrawn");
    req_rise_a: assert property ($rose(cmd_req_out) |-> !cmd_ack_in && !$past(cmd_ack_in))
        else $error("request raised over acknowledge");
    raw_hdr_a: assert property (cmd_req_out && ins_q == 8'hFE && idx_q inside {8'h2, 8'h3}
        |-> cmd_byte_out == ((idx_q == 8'h2) ? 8'h05 : 8'h00))
        else $error("pass-through parameters wrong");
    flags_ok_a: assert property (cmd_req_out && ins_q == 8'hFE && idx_q == 8'h5
        |-> (cmd_byte_out & 8'h95) == 8'h0 && cmd_byte_out[5] && cmd_byte_out[1])
        else $error("flags byte malformed");
    rsp_ack_a: assert property ($rose(rsp_ack_out) |-> rsp_req_in)
        else $error("answer acknowledged unasked");
    ack_fall_a: assert property ($fell(rsp_req_in) |-> ##[1:6] !rsp_ack_out)
        else $error("answer acknowledge stuck");
    reset_idle_a: assert property ($rose(rst_b_in) |-> !cmd_req_out && !busy_out && !rsp_ack_out)
        else $error("not idle after reset");
    slv_err_a: assert property (pslverr_out |-> psel_in && penable_in)
        else $error("error outside access phase");
endmodule : vmat_host_asserts
bind vmat_host vmat_host_asserts u_chk (.core_clk_in, .rst_b_in, .psel_in, .penable_in,
    .pslverr_out, .cmd_byte_out, .cmd_req_out, .cmd_ack_in, .rsp_req_in, .rsp_ack_out,
    .busy_out);
`default_nettype wire

// file: bench/vmat_dev_model.sv
`timescale 1ns/1ps
`default_nettype none
module vmat_dev_model (
    input wire logic core_clk_in,
    input wire logic slow_in,
    input wire logic [7:0] blk_in,
    input wire logic [7:0] cmd_byte_in,
    input wire logic cmd_req_in,
    output logic cmd_ack_out,
    output logic [7:0] rsp_byte_out,
    output logic rsp_last_out,
    output logic rsp_req_out,
    input wire logic rsp_ack_in
);
    logic [7:0] rx_q[$];
    logic [7:0] f[$];
    int n;
    task automatic take();
        do @(posedge core_clk_in); while (cmd_req_in !== 1'b1);
        f.push_back(cmd_byte_in);
        rx_q.push_back(cmd_byte_in);
        repeat (slow_in ? 6 : 1) @(posedge core_clk_in);
        cmd_ack_out <= 1'b1;
        do @(posedge core_clk_in); while (cmd_req_in !== 1'b0);
        cmd_ack_out <= 1'b0;
    endtask : take
    // Released byte shows its inverse so a late sample cannot pass
    task automatic give(input logic [7:0] b, input logic l);
        repeat (slow_in ? 4 : 1) @(posedge core_clk_in);
        rsp_byte_out <= b;
        rsp_last_out <= l;
        rsp_req_out <= 1'b1;
        do @(posedge core_clk_in); while (rsp_ack_in !== 1'b1);
        rsp_req_out <= 1'b0;
        rsp_byte_out <= ~b;
        rsp_last_out <= 1'b0;
        do @(posedge core_clk_in); while (rsp_ack_in !== 1'b0);
    endtask : give
    // Frame ends after Le, or after Lc data bytes
    initial begin
        cmd_ack_out = 1'b0;
        rsp_req_out = 1'b0;
        rsp_last_out = 1'b0;
        rsp_byte_out = 8'hA5;
        forever begin
            f.delete();
            repeat (5) take();
            if (f[1] != 8'hB0) repeat (f[4]) take();
            n = (f[1] != 8'hB0) ? 0 : (f[4] == 8'h0) ? int'(blk_in) : int'(f[4]);
            for (int i = 0; i < n; i++) give(8'(f[3] + i) ^ 8'h3C, 1'b0);
            give(8'h90, 1'b0);
            give(8'h00, 1'b1);
        end
    end
endmodule : vmat_dev_model
`default_nettype wire

// file: bench/tb_vmat_host.sv
`timescale 1ns/1ps
`default_nettype none
module tb_vmat_host;
    import vmat_pkg::*;
    logic core_clk_in = 1'b0;
    logic rst_b_in = 1'b0;
    logic psel_in = 1'b0;
    logic penable_in = 1'b0;
    logic pwrite_in = 1'b0;
    logic [7:0] paddr_in = 8'h0;
    logic [31:0] pwdata_in = 32'h0;
    logic [31:0] prdata_out;
    logic pready_out;
    logic pslverr_out;
    logic [7:0] cmd_byte_out;
    logic cmd_req_out;
    logic cmd_ack_in;
    logic [7:0] rsp_byte_in;
    logic rsp_last_in;
    logic rsp_req_in;
    logic rsp_ack_out;
    logic busy_out;
    logic slow = 1'b0;
    logic [7:0] bs = 8'h4;
    logic [31:0] rd;
    logic er;
    logic [7:0] codes[8] = '{8'h20, 8'h21, 8'h22, 8'h27, 8'h28, 8'h29, 8'h2A, 8'h2B};
    int fail_count = 0;
    int tests_run = 0;
    always #50 core_clk_in = ~core_clk_in;
    vmat_host dut (.core_clk_in, .rst_b_in, .psel_in, .penable_in, .pwrite_in, .paddr_in,
        .pwdata_in, .prdata_out, .pready_out, .pslverr_out, .cmd_byte_out, .cmd_req_out,
        .cmd_ack_in, .rsp_byte_in, .rsp_last_in, .rsp_req_in, .rsp_ack_out, .busy_out);
    vmat_dev_model u_dev (.core_clk_in, .slow_in(slow), .blk_in(bs), .cmd_byte_in(cmd_byte_out),
        .cmd_req_in(cmd_req_out), .cmd_ack_out(cmd_ack_in), .rsp_byte_out(rsp_byte_in),
        .rsp_last_out(rsp_last_in), .rsp_req_out(rsp_req_in), .rsp_ack_in(rsp_ack_out));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    // One transfer; request held until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int t;
        @(posedge core_clk_in);
        psel_in <= 1'b1;
        pwrite_in <= w;
        paddr_in <= a;
        pwdata_in <= d;
        @(posedge core_clk_in);
        penable_in <= 1'b1;
        t = 0;
        do begin
            @(posedge core_clk_in);
            t++;
        end while (pready_out !== 1'b1 && t < 20);
        rd = prdata_out;
        er = pslverr_out;
        psel_in <= 1'b0;
        penable_in <= 1'b0;
        if (t >= 20) fail_count++;
    endtask : apb
    task automatic summarize();
        if (fail_count == 0 && tests_run > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : summarize
    // Load payload, start, wait for done, then judge frame and answer
    task automatic run(input logic [1:0] op, input logic [1:0] fam, input logic [7:0] p1,
        input logic [7:0] p2, input logic [7:0] len, input logic ok,
        input logic [7:0] cmd = 8'h0, input logic [1:0] fl = 2'b00);
        logic [7:0] pay[$];
        logic [7:0] e[$];
        int n;
        int k;
        int hp;
        n = (op == OP_UPDATE) ? len : (op == OP_RAW && cmd == 8'h21) ? bs : 0;
        hp = op == OP_RAW && cmd inside {8'h20, 8'h21, 8'h22, 8'h27, 8'h29};
        slow = 1'($urandom);
        apb(1'b1, OFF_STATUS, 32'h2);
        apb(1'b1, OFF_PTR, 32'h0);
        for (k = 0; k < n; k++) begin
            pay.push_back(8'($urandom));
            apb(1'b1, OFF_DATA, {24'h0, pay[k]});
        end
        apb(1'b1, OFF_BSIZE, {28'h0, bs[3:0]});
        u_dev.rx_q.delete();
        apb(1'b1, OFF_PARAM, {cmd, len, p1, p2});
        apb(1'b1, OFF_CTRL, {25'h0, fl, fam, op, 1'b1});
        k = 0;
        do begin
            apb(1'b0, OFF_STATUS, 32'h0);
            k++;
        end while (rd[1] !== 1'b1 && k < 2000);
        check(rd[1], 1'b1);
        check(rd[2], !ok);
        if (ok && op == OP_RAW) begin
            e = '{8'hFF, 8'hFE, 8'h05, 8'h00, 8'(2 + hp + n),
                {1'b0, fl[0], 2'b10, fl[1], 3'b010}, cmd};
        end else if (ok) begin
            e = '{8'hFF, (op == OP_READ) ? 8'hB0 : 8'hD6, p1, p2, len};
        end
        if (ok && hp) e.push_back(p2);
        if (ok) e = {e, pay};
        check(u_dev.rx_q.size(), e.size());
        foreach (e[j]) check(u_dev.rx_q[j], e[j]);
        n = (op != OP_READ) ? 0 : (len == 8'h0) ? bs : len;
        if (ok) check(rd[31:8], {8'(n + 2), 16'h9000});
        if (ok && op == OP_READ) begin
            apb(1'b1, OFF_PTR, 32'h0);
            for (k = 0; k < n; k++) begin
                apb(1'b0, OFF_DATA, 32'h0);
                check(rd[7:0], 8'(p2 + k) ^ 8'h3C);
            end
        end
    endtask : run
    // Main sequence: reset values, traffic per family, refusals
    initial begin
        logic [7:0] b;
        void'($urandom(10310));
        repeat (12) @(posedge core_clk_in);
        rst_b_in <= 1'b1;
        apb(1'b0, OFF_BSIZE, 32'h0);
        check(rd[3:0], BSIZE_RST);
        apb(1'b0, OFF_STATUS, 32'h0);
        check(rd, 32'h0);
        apb(1'b0, 8'h18, 32'h0);
        check(er, 1'b1);
        for (int i = 0; i < 9; i++) begin
            b = 8'($urandom);
            bs = (i % 3 == 0) ? 8'h1 : (i % 3 == 1) ? 8'h4 : 8'h8;
            run(OP_READ, FAM_VICINITY_TAG, 8'h0, b, 8'(bs * $urandom_range(3)), 1'b1);
            run(OP_UPDATE, FAM_VICINITY_TAG, 8'h0, b, bs, 1'b1);
        end
        foreach (codes[j]) run(OP_RAW, 2'(j % 2), 8'h0, 8'($urandom), 8'h0, 1'b1, codes[j],
            2'($urandom));
        run(OP_READ, FAM_VICINITY_TAG_EXT, 8'($urandom_range(255, 1)), 8'h7, bs, 1'b1);
        run(OP_UPDATE, FAM_VICINITY_TAG_EXT, 8'h1, 8'hFF, bs, 1'b1);
        run(OP_READ, FAM_VICINITY_TAG, 8'h1, 8'h0, bs, 1'b0);
        run(OP_UPDATE, FAM_VICINITY_TAG, 8'h0, 8'h0, 8'h4, 1'b0);
        bs = 8'h10;
        run(OP_READ, FAM_T3, 8'h0, 8'h2, 8'h80, 1'b1);
        run(OP_READ, FAM_T3, 8'h0, 8'h5, 8'h0, 1'b1);
        run(OP_UPDATE, FAM_T3, 8'h0, 8'h1, 8'h10, 1'b1);
        run(OP_READ, FAM_T3, 8'h0, 8'h0, 8'h90, 1'b0);
        run(OP_READ, FAM_T3, 8'h0, 8'h0, 8'h18, 1'b0);
        run(OP_UPDATE, FAM_T3, 8'h0, 8'h0, 8'h8, 1'b0);
        run(OP_RAW, FAM_T3, 8'h0, 8'h0, 8'h0, 1'b0, 8'h20);
        bs = 8'h4;
        run(OP_READ, FAM_WORD, 8'h0, 8'hF, 8'h40, 1'b1);
        run(OP_UPDATE, FAM_WORD, 8'h0, 8'h3, 8'h4, 1'b1);
        run(OP_READ, FAM_WORD, 8'h0, 8'h10, 8'h4, 1'b0);
        run(OP_READ, FAM_WORD, 8'h0, 8'h0, 8'h6, 1'b0);
        run(OP_NONE, FAM_VICINITY_TAG, 8'h0, 8'h0, 8'h0, 1'b0);
        summarize();
    end
    // Watchdog well past the longest expected run
    initial begin
        #8000000;
        fail_count++;
        summarize();
    end
endmodule : tb_vmat_host
`default_nettype wire
